// [logic/bocp_pkg.sv]
/*
  Shared constants and types of the buck overcurrent protection block:
  register map, field layout, reset values, timing counts, channel states.
  Assumes a 10 MHz register-bus clock that also times the protection.
*/
`default_nettype none
package bocp_pkg;
  localparam int NCH = 4;
  // Register byte addresses
  localparam logic [31:0] ADDR_LIMIT  = 32'h0000_0000;
  localparam logic [31:0] ADDR_VREF   = 32'h0000_0004;
  localparam logic [31:0] ADDR_CONFIG = 32'h0000_0008;
  localparam logic [31:0] ADDR_CMD    = 32'h0000_000C;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
  // Decoded register index
  localparam logic [2:0] IDX_LIMIT  = 3'h0;
  localparam logic [2:0] IDX_VREF   = 3'h1;
  localparam logic [2:0] IDX_CONFIG = 3'h2;
  localparam logic [2:0] IDX_CMD    = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;
  localparam logic [2:0] IDX_NONE   = 3'h7;
  // Field positions
  localparam int LIM_STRIDE     = 4;
  localparam int CFG_PAIR_LSB   = 0;
  localparam int CFG_SSDIG_LSB  = 2;
  localparam int CMD_STORE_BIT  = 0;
  localparam int ST_SHUT_LSB    = 0;
  localparam int ST_OC_LSB      = 4;
  localparam int ST_SOFT_LSB    = 8;
  localparam int ST_SUPPLY_BIT  = 12;
  // Limit codes: ch 1/2 0..4 = 2..6 A, ch 3/4 0..3 = 0.5,1,2,3 A
  localparam logic [2:0] LIM12_MAX = 3'h4;
  localparam logic [2:0] LIM34_MAX = 3'h3;
  localparam logic [2:0] LIM12_DEF = 3'h4;
  localparam logic [2:0] LIM34_DEF = 3'h3;
  // Reference code: 0.6 V + 10 mV per step, 0..127 = 0.6..1.87 V
  localparam logic [6:0] VREF_DEF  = 7'h14;
  // Event counts
  localparam logic [8:0] HS_TRIP_CNT = 9'h100;
  localparam logic [8:0] LS_TRIP_CNT = 9'h0FF;
  localparam logic [2:0] CLEAN_LAST  = 3'h5;
  // Timing
  localparam int CLK_KHZ          = 10000;
  localparam int SHUT_TIME_US     = 20000;
  localparam int COMP_LOW_TIME_US = 1100;
  localparam int SHUT_CYCLES      = SHUT_TIME_US * CLK_KHZ / 1000;
  localparam int COMP_LOW_CYCLES  = COMP_LOW_TIME_US * CLK_KHZ / 1000;
  localparam int TMR_W            = 18;

  typedef enum logic [6:0] {
    BOCP_RUN   = 7'h01,
    BOCP_LIMIT = 7'h02,
    BOCP_SKIP  = 7'h04,
    BOCP_LSOC  = 7'h08,
    BOCP_WAIT  = 7'h10,
    BOCP_SHUT  = 7'h20,
    BOCP_SOFT  = 7'h40
  } bocp_st_t;

  typedef struct packed {
    logic [3:0][2:0] limit;
    logic [6:0]      vref;
    logic [1:0]      pair;
    logic [3:0]      ss_digital;
  } bocp_cfg_t;

  localparam bocp_cfg_t CFG_DEF = '{limit: {LIM34_DEF, LIM34_DEF, LIM12_DEF, LIM12_DEF},
                                    vref: VREF_DEF, pair: 2'h0, ss_digital: 4'h0};

  typedef struct packed {
    bocp_st_t         state;
    logic [8:0]       hs_cnt;
    logic [8:0]       ls_cnt;
    logic [2:0]       clean;
    logic [TMR_W-1:0] tmr;
  } bocp_ch_t;

  localparam bocp_ch_t CH_RST = '{state: BOCP_SOFT, hs_cnt: 9'h000, ls_cnt: 9'h000,
                                  clean: 3'h0, tmr: 18'h0_0000};

  typedef struct packed {
    logic [3:0] hs_allow;
    logic [3:0] ls_allow;
    logic [3:0] ls_hold;
    logic [3:0] comp_clamp;
    logic [3:0] ea_tristate;
    logic [3:0] comp_pull_low;
    logic [3:0] ss_discharge;
    logic [3:0] ss_value_clear;
    logic [3:0] soft_start_go;
  } bocp_gate_t;

  localparam bocp_gate_t GATE_RST = '{soft_start_go: 4'hF, hs_allow: 4'hF,
                                      ls_allow: 4'hF, default: 4'h0};

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] f;
  } bocp_sync_t;

  typedef struct packed {
    logic        wr_pend;
    logic [2:0]  wr_idx;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } bocp_bus_t;

  typedef struct packed {
    bocp_cfg_t           cfg;
    bocp_cfg_t           nv;
    bocp_ch_t [NCH-1:0]  ch;
    bocp_sync_t          sync;
    bocp_gate_t          gate;
    bocp_bus_t           bus;
  } bocp_all_t;
endpackage
`default_nettype wire

// [logic/bocp_top.sv]
/*
  Overcurrent protection for four buck switchers: cycle skipping, sustained
  overcurrent shutdown with timed restart, low-side protection, paired
  channels, configuration store and restore, AHB-Lite register slave.
  Assumes comparators and supply flag arrive asynchronously, switching-cycle
  ticks and soft-start completion come from logic on hclk.
*/
// Implementation choices: the address map and the AHB-Lite register port.
// Notes on behaviour
// - Peak limit per switcher programmable; default 6 A ch1/2, 3 A ch3/4.
// - High-side limit reached: high side off, low side off rest of cycle.
// - Cycle after a limited cycle is skipped with both switches off.
// - Keep skipping cycles while current stays above the limit.
// - Limit on more than 256 consecutive active cycles: 20 ms shutdown, restart.
// - Paired switchers both shut down when either one trips.
// - After the shutdown interval restart through full soft-start.
// - During that shutdown hold the compensation node low for 1.1 ms.
// - Discharge the soft-start pin for the same 1.1 ms.
// - Digital soft-start value reset on overcurrent shutdown.
// - Low-side overcurrent: low side stays on, high side off until clear.
// - After low-side overcurrent, next cycle starts only at next clock tick.
// - Low-side events counted; shutdown when count reaches 256.
// - Low-side counter clears after six consecutive clean cycles.
// - Paired mode: no 0.6 V clamp; error amplifier tri-stated instead.
// - Store command copies configuration into non-volatile image.
// - On supply return the configuration reloads from that image.
// - Reference default 0.8 V, programmable 0.6 to 1.87 V.
// - During soft-start all detection disabled and unfaulted; a tripping paired partner still shuts the channel down.
`timescale 1ns/10ps
`default_nettype none
module bocp_top #(
  parameter int unsigned SHUT_CYCLES     = bocp_pkg::SHUT_CYCLES,
  parameter int unsigned COMP_LOW_CYCLES = bocp_pkg::COMP_LOW_CYCLES
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire logic [3:0]           hs_overcurrent,
  input  wire logic [3:0]           ls_overcurrent,
  input  wire logic [3:0]           pwm_tick,
  input  wire logic [3:0]           soft_start_done,
  input  wire logic                 supply_ok,
  output bocp_pkg::bocp_gate_t      gate_ctl,
  output logic [3:0][2:0]           peak_current_limit,
  output logic [6:0]                vref_code
);
  localparam logic [bocp_pkg::TMR_W-1:0] SHUT_LAST = bocp_pkg::TMR_W'(SHUT_CYCLES - 1);
  localparam logic [bocp_pkg::TMR_W-1:0] COMP_LAST = bocp_pkg::TMR_W'(COMP_LOW_CYCLES);

  bocp_pkg::bocp_all_t r;
  bocp_pkg::bocp_all_t nxt;

  // Word-aligned decode of the five registers, IDX_NONE elsewhere
  function automatic logic [2:0] bocp_dec(input logic [31:0] a);
    case (a)
      bocp_pkg::ADDR_LIMIT:  bocp_dec = bocp_pkg::IDX_LIMIT;
      bocp_pkg::ADDR_VREF:   bocp_dec = bocp_pkg::IDX_VREF;
      bocp_pkg::ADDR_CONFIG: bocp_dec = bocp_pkg::IDX_CONFIG;
      bocp_pkg::ADDR_CMD:    bocp_dec = bocp_pkg::IDX_CMD;
      bocp_pkg::ADDR_STATUS: bocp_dec = bocp_pkg::IDX_STATUS;
      default:               bocp_dec = bocp_pkg::IDX_NONE;
    endcase
  endfunction

  // Limit codes beyond a channel's option list are refused
  function automatic logic bocp_lim_ok(input int ch, input logic [2:0] code);
    if (ch < 2) begin
      bocp_lim_ok = (code <= bocp_pkg::LIM12_MAX);
    end else begin
      bocp_lim_ok = (code <= bocp_pkg::LIM34_MAX);
    end
  endfunction

  // Whole next-state computation
  always_comb begin
    logic [3:0]  trip;
    logic [3:0]  shut_go;
    logic        sup_rise;
    logic [2:0]  aidx;
    logic [31:0] rd;
    bocp_pkg::bocp_st_t st;
    trip     = 4'h0;
    shut_go  = 4'h0;
    sup_rise = 1'b0;
    aidx     = bocp_dec(haddr);
    rd       = 32'h0000_0000;
    st       = bocp_pkg::BOCP_SOFT;
    nxt      = r;

    // Three-stage synchronisers; a change counts once stages two and three agree
    nxt.sync.s1 = {supply_ok, ls_overcurrent, hs_overcurrent};
    nxt.sync.s2 = r.sync.s1;
    nxt.sync.s3 = r.sync.s2;
    for (int b = 0; b < 9; b++) begin
      if (r.sync.s2[b] == r.sync.s3[b]) begin
        nxt.sync.f[b] = r.sync.s3[b];
      end
    end
    sup_rise = nxt.sync.f[8] & ~r.sync.f[8];

    // Supply loss drops to defaults; supply return reloads the stored image
    // The rise is tested first: on that edge the filtered supply is still low
    if (sup_rise) begin
      nxt.cfg = r.nv;
    end else if (!r.sync.f[8]) begin
      nxt.cfg = bocp_pkg::CFG_DEF;
    end

    // Sustained-overcurrent trips, then spread across a configured pair
    for (int i = 0; i < 4; i++) begin
      if (r.sync.f[8] && r.ch[i].state == bocp_pkg::BOCP_RUN) begin
        if (r.sync.f[i] && r.ch[i].hs_cnt == bocp_pkg::HS_TRIP_CNT) begin
          trip[i] = 1'b1;
        end else if (!r.sync.f[i] && r.sync.f[4+i] &&
                     r.ch[i].ls_cnt == bocp_pkg::LS_TRIP_CNT) begin
          trip[i] = 1'b1;
        end
      end
    end
    for (int i = 0; i < 4; i++) begin
      shut_go[i] = (trip[i] | (r.cfg.pair[i/2] & trip[i ^ 1])) &
                   (r.ch[i].state != bocp_pkg::BOCP_SHUT);
    end

    // Per-channel protection state machines
    for (int i = 0; i < 4; i++) begin
      if (!r.sync.f[8]) begin
        nxt.ch[i] = bocp_pkg::CH_RST;
      end else if (shut_go[i]) begin
        nxt.ch[i]       = bocp_pkg::CH_RST;
        nxt.ch[i].state = bocp_pkg::BOCP_SHUT;
      end else begin
        case (r.ch[i].state)
          bocp_pkg::BOCP_RUN: begin
            if (r.sync.f[i]) begin
              nxt.ch[i].state  = bocp_pkg::BOCP_LIMIT;
              nxt.ch[i].hs_cnt = r.ch[i].hs_cnt + 9'h001;
            end else if (r.sync.f[4+i]) begin
              nxt.ch[i].state  = bocp_pkg::BOCP_LSOC;
              nxt.ch[i].ls_cnt = r.ch[i].ls_cnt + 9'h001;
              nxt.ch[i].clean  = 3'h0;
            end else if (pwm_tick[i]) begin
              nxt.ch[i].hs_cnt = 9'h000;
              if (r.ch[i].clean == bocp_pkg::CLEAN_LAST) begin
                nxt.ch[i].clean  = 3'h0;
                nxt.ch[i].ls_cnt = 9'h000;
              end else begin
                nxt.ch[i].clean = r.ch[i].clean + 3'h1;
              end
            end
          end
          bocp_pkg::BOCP_LIMIT: begin
            if (pwm_tick[i]) begin
              nxt.ch[i].state = bocp_pkg::BOCP_SKIP;
            end
          end
          bocp_pkg::BOCP_SKIP: begin
            if (pwm_tick[i] && !r.sync.f[i]) begin
              nxt.ch[i].state = bocp_pkg::BOCP_RUN;
            end
          end
          bocp_pkg::BOCP_LSOC: begin
            if (!r.sync.f[4+i]) begin
              nxt.ch[i].state = bocp_pkg::BOCP_WAIT;
            end
          end
          bocp_pkg::BOCP_WAIT: begin
            if (pwm_tick[i]) begin
              nxt.ch[i].state = bocp_pkg::BOCP_RUN;
            end
          end
          bocp_pkg::BOCP_SHUT: begin
            // Interval counted on hclk, so it does not stretch with the switching clock
            if (r.ch[i].tmr == SHUT_LAST) begin
              nxt.ch[i].state = bocp_pkg::BOCP_SOFT;
              nxt.ch[i].tmr   = '0;
            end else begin
              nxt.ch[i].tmr = r.ch[i].tmr + 18'h0_0001;
            end
          end
          bocp_pkg::BOCP_SOFT: begin
            // Comparators ignored here, counters held clear
            if (soft_start_done[i]) begin
              nxt.ch[i].state = bocp_pkg::BOCP_RUN;
            end
          end
          default: begin
            nxt.ch[i] = bocp_pkg::CH_RST;
          end
        endcase
      end
    end

    // Gate and analog controls follow the next state, so they register with it
    for (int i = 0; i < 4; i++) begin
      st = nxt.ch[i].state;
      nxt.gate.hs_allow[i] = (st == bocp_pkg::BOCP_RUN) || (st == bocp_pkg::BOCP_SOFT);
      nxt.gate.ls_allow[i] = (st == bocp_pkg::BOCP_RUN) || (st == bocp_pkg::BOCP_SOFT) ||
                             (st == bocp_pkg::BOCP_LSOC);
      nxt.gate.ls_hold[i]  = (st == bocp_pkg::BOCP_LSOC);
      nxt.gate.comp_clamp[i]  = (st == bocp_pkg::BOCP_LIMIT || st == bocp_pkg::BOCP_SKIP ||
                                 st == bocp_pkg::BOCP_LSOC || st == bocp_pkg::BOCP_WAIT) &&
                                !nxt.cfg.pair[i/2];
      nxt.gate.ea_tristate[i] = (st == bocp_pkg::BOCP_LIMIT || st == bocp_pkg::BOCP_SKIP ||
                                 st == bocp_pkg::BOCP_LSOC || st == bocp_pkg::BOCP_WAIT) &&
                                nxt.cfg.pair[i/2];
      nxt.gate.comp_pull_low[i] = (st == bocp_pkg::BOCP_SHUT) &&
                                  (nxt.ch[i].tmr < COMP_LAST);
      nxt.gate.ss_discharge[i]  = (st == bocp_pkg::BOCP_SHUT) &&
                                  (nxt.ch[i].tmr < COMP_LAST);
      nxt.gate.ss_value_clear[i] = (st == bocp_pkg::BOCP_SHUT) &&
                                   nxt.cfg.ss_digital[i];
      nxt.gate.soft_start_go[i]  = (st == bocp_pkg::BOCP_SOFT);
    end

    // AHB-Lite: zero wait states, reads registered in the address phase
    nxt.bus.wr_pend   = 1'b0;
    nxt.bus.hreadyout = 1'b1;
    nxt.bus.hresp     = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        nxt.bus.wr_pend = 1'b1;
        nxt.bus.wr_idx  = aidx;
      end else begin
        case (aidx)
          bocp_pkg::IDX_LIMIT: begin
            for (int i = 0; i < 4; i++) begin
              rd[i*bocp_pkg::LIM_STRIDE +: 3] = r.cfg.limit[i];
            end
          end
          bocp_pkg::IDX_VREF:   rd[6:0] = r.cfg.vref;
          bocp_pkg::IDX_CONFIG: begin
            rd[bocp_pkg::CFG_PAIR_LSB +: 2]  = r.cfg.pair;
            rd[bocp_pkg::CFG_SSDIG_LSB +: 4] = r.cfg.ss_digital;
          end
          bocp_pkg::IDX_STATUS: begin
            for (int i = 0; i < 4; i++) begin
              rd[bocp_pkg::ST_SHUT_LSB + i] = (r.ch[i].state == bocp_pkg::BOCP_SHUT);
              rd[bocp_pkg::ST_OC_LSB + i]   = r.gate.comp_clamp[i] | r.gate.ea_tristate[i];
              rd[bocp_pkg::ST_SOFT_LSB + i] = (r.ch[i].state == bocp_pkg::BOCP_SOFT);
            end
            rd[bocp_pkg::ST_SUPPLY_BIT] = r.sync.f[8];
          end
          default: rd = 32'h0000_0000;
        endcase
      end
      nxt.bus.hrdata = rd;
    end

    // Data-phase writes; ignored while the supply is down
    if (r.bus.wr_pend && r.sync.f[8]) begin
      case (r.bus.wr_idx)
        bocp_pkg::IDX_LIMIT: begin
          for (int i = 0; i < 4; i++) begin
            if (bocp_lim_ok(i, hwdata[i*bocp_pkg::LIM_STRIDE +: 3])) begin
              nxt.cfg.limit[i] = hwdata[i*bocp_pkg::LIM_STRIDE +: 3];
            end
          end
        end
        bocp_pkg::IDX_VREF:   nxt.cfg.vref = hwdata[6:0];
        bocp_pkg::IDX_CONFIG: begin
          nxt.cfg.pair       = hwdata[bocp_pkg::CFG_PAIR_LSB +: 2];
          nxt.cfg.ss_digital = hwdata[bocp_pkg::CFG_SSDIG_LSB +: 4];
        end
        bocp_pkg::IDX_CMD: begin
          if (hwdata[bocp_pkg::CMD_STORE_BIT]) begin
            nxt.nv = r.cfg;
          end
        end
        default: nxt.nv = nxt.nv;
      endcase
    end
  end

  // Single state register; the stored image only returns to CFG_DEF on hresetn
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.cfg      <= bocp_pkg::CFG_DEF;
      r.nv       <= bocp_pkg::CFG_DEF;
      r.ch       <= {4{bocp_pkg::CH_RST}};
      r.sync     <= '0;
      r.gate     <= bocp_pkg::GATE_RST;
      r.bus      <= '{wr_pend: 1'b0, wr_idx: bocp_pkg::IDX_NONE, hreadyout: 1'b1,
                      hresp: 1'b0, hrdata: 32'h0000_0000};
    end else begin
      r <= nxt;
    end
  end

  // Outputs straight from the state register
  assign hreadyout          = r.bus.hreadyout;
  assign hrdata             = r.bus.hrdata;
  assign hresp              = r.bus.hresp;
  assign gate_ctl           = r.gate;
  assign peak_current_limit = r.cfg.limit;
  assign vref_code          = r.cfg.vref;

  // Per-channel checks
  for (genvar g = 0; g < 4; g++) begin : g_chk
    a_limit_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_RUN && r.sync.f[g])
      |=> (!r.gate.hs_allow[g] && !r.gate.ls_allow[g]))
      else $error("high side not cut on limit");
    a_skip_after_lim: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_LIMIT && pwm_tick[g])
      |=> (r.ch[g].state inside {bocp_pkg::BOCP_SKIP, bocp_pkg::BOCP_SHUT})
          && !r.gate.hs_allow[g] && !r.gate.ls_allow[g])
      else $error("cycle after limit not skipped");
    a_skip_persist: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_SKIP && pwm_tick[g] && r.sync.f[g])
      |=> (r.ch[g].state inside {bocp_pkg::BOCP_SKIP, bocp_pkg::BOCP_SHUT}))
      else $error("skipping stopped while over limit");
    a_hs_trip_shut: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_RUN && r.sync.f[g] &&
       r.ch[g].hs_cnt == bocp_pkg::HS_TRIP_CNT)
      |=> r.ch[g].state == bocp_pkg::BOCP_SHUT ##1 r.ch[g].tmr == 18'h0_0001)
      else $error("no shutdown after sustained limit");
    a_pair_shut: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.cfg.pair[g/2] && $rose(r.ch[g].state == bocp_pkg::BOCP_SHUT))
      |-> r.ch[g^1].state == bocp_pkg::BOCP_SHUT)
      else $error("partner not shut down");
    a_shut_to_soft: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_SHUT && r.ch[g].tmr == SHUT_LAST)
      |=> (r.ch[g].state == bocp_pkg::BOCP_SOFT && r.gate.soft_start_go[g]))
      else $error("no soft-start after shutdown");
    a_comp_low_start: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(r.ch[g].state == bocp_pkg::BOCP_SHUT)
      |-> (r.gate.comp_pull_low[g] && r.gate.ss_discharge[g]))
      else $error("comp not pulled low at shutdown");
    a_ss_with_comp: assert property (@(posedge hclk) disable iff (!hresetn)
      r.gate.ss_discharge[g] |-> (r.gate.comp_pull_low[g] &&
                                  r.ch[g].state == bocp_pkg::BOCP_SHUT &&
                                  r.ch[g].tmr < COMP_LAST))
      else $error("discharge outside pull-low window");
    a_ls_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_LSOC && r.sync.f[4+g])
      |=> ((r.gate.ls_hold[g] && !r.gate.hs_allow[g]) ||
           r.ch[g].state == bocp_pkg::BOCP_SHUT))
      else $error("low-side hold released early");
    a_wait_tick: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_WAIT && !pwm_tick[g])
      |=> !r.gate.hs_allow[g])
      else $error("cycle restarted before tick");
    a_ls_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_RUN && pwm_tick[g] &&
       !r.sync.f[g] && !r.sync.f[4+g] && r.ch[g].clean == bocp_pkg::CLEAN_LAST)
      |=> r.ch[g].ls_cnt == 9'h000)
      else $error("low-side count not cleared");
    a_pair_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
      r.gate.ea_tristate[g] |-> (r.cfg.pair[g/2] && !r.gate.comp_clamp[g]))
      else $error("tri-state outside paired mode");
    a_soft_blind: assert property (@(posedge hclk) disable iff (!hresetn)
      (r.sync.f[8] && r.ch[g].state == bocp_pkg::BOCP_SOFT && !soft_start_done[g])
      |=> (r.ch[g].state inside {bocp_pkg::BOCP_SOFT, bocp_pkg::BOCP_SHUT}))
      else $error("fault acted during soft-start");
  end
endmodule // bocp_top
`default_nettype wire

// [testbench/bocp_stage.sv]
/*
  Power stage stand-in: switching ticks, soft-start ramp and current comparators.
  Assumes hclk timing; overcurrent levels are requested by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module bocp_stage (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire bocp_pkg::bocp_gate_t gate_ctl,
  input  wire logic [3:0]           hs_req,
  input  wire logic [3:0]           ls_req,
  output logic [3:0]                pwm_tick,
  output logic [3:0]                soft_start_done,
  output logic [3:0]                hs_overcurrent,
  output logic [3:0]                ls_overcurrent
);
  logic [3:0]      div_r;
  logic [3:0][4:0] ramp_r;
  // Short shared period keeps long trip counts affordable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 4'h0;
      ramp_r <= '0;
    end else begin
      div_r <= (div_r == 4'hB) ? 4'h0 : div_r + 4'h1;
      for (int i = 0; i < 4; i++) begin
        if (!gate_ctl.soft_start_go[i])
          ramp_r[i] <= 5'h00;
        else if (!ramp_r[i][4])
          ramp_r[i] <= ramp_r[i] + 5'h01;
      end
    end
  end
  // Ramp done after 16 cycles; comparators follow the requests
  assign pwm_tick        = {4{div_r == 4'h0}};
  assign soft_start_done = {ramp_r[3][4], ramp_r[2][4], ramp_r[1][4], ramp_r[0][4]};
  assign hs_overcurrent  = hs_req;
  assign ls_overcurrent  = ls_req;
endmodule // bocp_stage
`default_nettype wire

// [testbench/buck_overcurrent_protection_test.sv]
/*
  Self-checking bench of the overcurrent protection block with a power stage model.
  Assumes shortened shutdown counts (200 and 11 cycles) and a 10 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module buck_overcurrent_protection_test;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, supply_ok = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q, p, v, e;
  logic [3:0] hs_req = 4'h0, ls_req = 4'h0, tick, ssd, hso, lso;
  logic hreadyout, hresp;
  logic [3:0][2:0] lim;
  logic [11:0] f;
  logic [6:0] vref;
  bocp_pkg::bocp_gate_t g;
  int errors = 0, compares = 0, cyc = 0, seed = 37003, n, k, lm[4] = '{4, 4, 3, 3};
  bocp_top #(.SHUT_CYCLES(200), .COMP_LOW_CYCLES(11)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .hs_overcurrent(hso), .ls_overcurrent(lso), .pwm_tick(tick), .soft_start_done(ssd),
    .supply_ok(supply_ok), .gate_ctl(g), .peak_current_limit(lim), .vref_code(vref));
  bocp_stage i_stage (.hclk(hclk), .hresetn(hresetn), .gate_ctl(g), .hs_req(hs_req),
    .ls_req(ls_req), .pwm_tick(tick), .soft_start_done(ssd), .hs_overcurrent(hso),
    .ls_overcurrent(lso));
  // Clock and hang guard
  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      errors++;
      $display("BAD %s exp %h saw %h", nm, x, s);
    end
  endtask
  // One single AHB transfer; caller stands just after an edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", {hreadyout, hresp}, 32'h0000_0002);
  endtask
  task automatic tk(input int c);
    repeat (c) do @(posedge hclk); while (tick[0] !== 1'b1);
  endtask
  // Raise one comparator until the high side is blocked, then drop it
  task automatic hit(input int c, input logic ls);
    if (ls) ls_req[c] <= 1'b1;
    else hs_req[c] <= 1'b1;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (g.hs_allow[c] !== 1'b0 && n < 40);
    hs_req[c] <= 1'b0;
    ls_req[c] <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("lim_def", lim, 12'h6E4);
    bus(1'b0, bocp_pkg::ADDR_VREF, 0);
    chk("vref_def", q, 32'h0000_0014);
    bus(1'b0, 32'h0000_0014, 0);
    chk("unmapped", q, 0);
    repeat (6) begin
      p = $random(seed);
      bus(1'b1, bocp_pkg::ADDR_LIMIT, p);
      bus(1'b0, bocp_pkg::ADDR_LIMIT, 0);
      e = 0;
      for (int i = 0; i < 4; i++) begin
        if (p[4*i +: 3] <= (i < 2 ? 3'h4 : 3'h3)) lm[i] = p[4*i +: 3];
        e[4*i +: 3] = lm[i][2:0];
        f[3*i +: 3] = lm[i][2:0];
      end
      chk("lim_rd", q, e);
      chk("lim_out", lim, f);
    end
    v = $random(seed);
    bus(1'b1, bocp_pkg::ADDR_VREF, v);
    bus(1'b0, bocp_pkg::ADDR_VREF, 0);
    chk("vref_rd", q, {25'h0, v[6:0]});
    $display("registers done");
    bus(1'b1, bocp_pkg::ADDR_CMD, 32'h0000_0001);
    bus(1'b1, bocp_pkg::ADDR_VREF, 0);
    bus(1'b1, bocp_pkg::ADDR_LIMIT, 0);
    supply_ok <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("vref_off", vref, 7'h14);
    supply_ok <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("vref_back", vref, v[6:0]);
    chk("lim_back", lim, f);
    $display("store done");
    bus(1'b1, bocp_pkg::ADDR_CONFIG, 32'h0000_0005);
    repeat (40) @(posedge hclk);
    hit(0, 1'b0);
    chk("hs_cut", g.hs_allow[0] | g.ls_allow[0], 0);
    chk("ea_off", {g.ea_tristate[0], g.comp_clamp[0]}, 2'h2);
    tk(1);
    @(posedge hclk);
    chk("skip", g.hs_allow[0] | g.ls_allow[0], 0);
    tk(1);
    @(posedge hclk);
    chk("resume", g.hs_allow[0], 1);
    hs_req[0] <= 1'b1;
    tk(3);
    chk("held", g.hs_allow[0], 0);
    hs_req[0] <= 1'b0;
    tk(2);
    @(posedge hclk);
    chk("resume2", g.hs_allow[0], 1);
    for (k = 0; k < 256; k++) begin
      hit(0, 1'b0);
      tk(2);
    end
    chk("no_trip", g.soft_start_go[0] | g.comp_pull_low[0], 0);
    hit(0, 1'b0);
    chk("shut", {g.comp_pull_low[0], g.ss_discharge[0], g.ss_value_clear[0],
                 g.hs_allow[1]}, 4'hE);
    n = 0;
    k = 1;
    while (g.soft_start_go[0] !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
      k += g.comp_pull_low[0];
    end
    chk("pull_len", k, 11);
    chk("shut_len", n, 200);
    chk("restart", g.soft_start_go[1:0], 2'h3);
    $display("high side done");
    repeat (40) @(posedge hclk);
    hit(2, 1'b1);
    chk("ls_hold", {g.ls_hold[2], g.hs_allow[2]}, 2'h2);
    n = 0;
    while (g.ls_hold[2] !== 1'b0 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk("ls_wait", g.hs_allow[2], 0);
    tk(2);
    for (k = 1; k < 255; k++) begin
      hit(2, 1'b1);
      tk(2);
    end
    chk("ls_255", g.comp_pull_low[2], 0);
    hit(2, 1'b1);
    chk("ls_trip", g.comp_pull_low[2], 1);
    bus(1'b0, bocp_pkg::ADDR_STATUS, 0);
    chk("status", q, 32'h0000_1004);
    $display("low side done");
    report_and_stop();
  end
endmodule // buck_overcurrent_protection_test
`default_nettype wire
